/* File: podu_evt_if.sv */
// event carrier between the control core and its detectors
`timescale 1ns/1ns
interface podu_evt_if
	import podu_pkg::*;
();
	logic [2:0] tick;
	podu_mode_e mode [REQ_N];
	logic [REQ_N-1:0] req_det;
	logic [PIN_N-1:0] level;
	logic [PIN_N-1:0] active_level;
	logic [PAIR_N-1:0] short_det;

	modport ctrl (output tick, mode, level, active_level, input req_det, short_det);
	modport det (input tick, mode, output req_det);
	modport cmp (input level, active_level, output short_det);
endinterface : podu_evt_if

/* File: podu_pair_cmp.sv */
// short-circuit comparison of complementary output pairs
`timescale 1ns/1ns
module podu_pair_cmp
	import podu_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	podu_evt_if.cmp evt
);
	logic [PAIR_N-1:0] short_r;
	logic [PAIR_N-1:0] short_nxt;

	// both members at their active level in the same cycle
	always_comb begin
		for (int j = 0; j < PAIR_N; j++) begin
			short_nxt[j] = (evt.level[PAIR_A_IDX[j]] == evt.active_level[PAIR_A_IDX[j]])
				&& (evt.level[PAIR_B_IDX[j]] == evt.active_level[PAIR_B_IDX[j]]);
		end
	end

	// one cycle of overlap is enough to report
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			short_r <= '0;
		end else begin
			short_r <= short_nxt;
		end
	end

	assign evt.short_det = short_r;

endmodule : podu_pair_cmp

/* File: podu_pkg.sv */
// shared constants, field layouts and types of the port output disable unit
package podu_pkg;

	// structure of the block
	localparam int REQ_N = 5;
	localparam int PAIR_N = 6;
	localparam int PIN_N = 16;
	localparam int ST_W = 12;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;

	// low-level sampling: count of samples and sampling clock dividers
	localparam int LOW_SAMPLES = 16;
	localparam int DIV_8 = 8;
	localparam int DIV_16 = 16;
	localparam int DIV_128 = 128;
	localparam int PRESC_W = 7;

	// register byte offsets
	localparam logic [7:0] ADDR_ICSR_BASE = 8'h00;
	localparam logic [7:0] ADDR_ICSR_STEP = 8'h02;
	localparam logic [7:0] ADDR_SW_HIZ = 8'h0A;
	localparam logic [7:0] ADDR_OEC1 = 8'h0C;
	localparam logic [7:0] ADDR_OEC2 = 8'h0E;
	localparam logic [7:0] ADDR_ACT_LVL = 8'h10;
	localparam logic [7:0] ADDR_OSC_CTRL = 8'h12;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
	localparam logic [7:0] ADDR_IRQ_CLR = 8'h16;
	localparam logic [7:0] ADDR_IRQ_EN = 8'h18;

	// input level control/status layout, same for every request input
	localparam int ICSR_MODE_LSB = 0;
	localparam int ICSR_HIZ_BIT = 8;
	localparam int ICSR_PIE_BIT = 9;
	localparam int ICSR_FLAG_BIT = 12;

	// software request bits
	localparam int SW_CH34_BIT = 0;
	localparam int SW_CH67_BIT = 1;
	localparam int SW_CH0_BIT = 2;

	// pairs: 3B/3D, 4A/4C, 4B/4D, 6B/6D, 7A/7C, 7B/7D
	localparam int PAIR_A_IDX [PAIR_N] = '{4, 6, 7, 10, 12, 13};
	localparam int PAIR_B_IDX [PAIR_N] = '{5, 8, 9, 11, 14, 15};
	localparam int PAIR_EN_BIT [PAIR_N] = '{10, 9, 8, 2, 1, 0};

	// pin groups
	localparam logic [15:0] CH0_MASK = 16'h000F;
	localparam logic [15:0] CH34_MASK = 16'h03F0;
	localparam logic [15:0] CH67_MASK = 16'hFC00;

	// status layout
	localparam int ST_REQ_LSB = 0;
	localparam int ST_PAIR_LSB = 5;
	localparam int ST_OSC_BIT = 11;

	// reset values
	localparam logic [15:0] ACT_LVL_RST = 16'hFFFF;

	// detection modes of a request input
	typedef enum logic [1:0] {
		PODU_MODE_FALL,
		PODU_MODE_LOW8,
		PODU_MODE_LOW16,
		PODU_MODE_LOW128
	} podu_mode_e;

endpackage : podu_pkg

/* File: podu_req_det.sv */
// request input synchronisers with falling-edge and low-level detection
`timescale 1ns/1ns
module podu_req_det
	import podu_pkg::*;
#(
	parameter int N = REQ_N,
	parameter int SAMPLES = LOW_SAMPLES
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [N-1:0] req_in_n,
	podu_evt_if.det evt
);
	localparam int CW = $clog2(SAMPLES + 1);
	localparam logic [CW-1:0] CNT_FULL = CW'(SAMPLES);

	if (SAMPLES < 2 || N != REQ_N) begin : g_chk
		$error("podu_req_det: unsupported SAMPLES or N");
	end

	for (genvar i = 0; i < N; i++) begin : g_in
		logic [2:0] pipe_r; // stage 0, stage 1, previous
		logic [2:0] pipe_nxt;
		logic [CW-1:0] cnt_r;
		logic [CW-1:0] cnt_nxt;
		logic det_r;
		logic det_nxt;
		logic low_mode;
		logic tick_sel;

		// sample counting and edge detection
		always_comb begin
			low_mode = (evt.mode[i] != PODU_MODE_FALL);
			unique case (evt.mode[i])
				PODU_MODE_FALL: tick_sel = 1'b0;
				PODU_MODE_LOW8: tick_sel = evt.tick[0];
				PODU_MODE_LOW16: tick_sel = evt.tick[1];
				PODU_MODE_LOW128: tick_sel = evt.tick[2];
			endcase
			pipe_nxt = {pipe_r[1:0], req_in_n[i]};
			cnt_nxt = cnt_r;
			if (!low_mode) begin
				cnt_nxt = '0;
			end else if (tick_sel) begin
				if (pipe_r[1]) begin
					cnt_nxt = '0; // any high sample restarts the run
				end else if (cnt_r != CNT_FULL) begin
					cnt_nxt = cnt_r + 1'b1;
				end
			end
			if (low_mode) begin
				det_nxt = (cnt_nxt == CNT_FULL);
			end else begin
				det_nxt = pipe_r[2] & ~pipe_r[1];
			end
		end

		// registers, pins idle high
		always_ff @(posedge ref_clk) begin
			if (!reset_n) begin
				pipe_r <= 3'h7;
				cnt_r <= '0;
				det_r <= 1'b0;
			end else begin
				pipe_r <= pipe_nxt;
				cnt_r <= cnt_nxt;
				det_r <= det_nxt;
			end
		end

		assign evt.req_det[i] = det_r;

		low_count_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
			(low_mode && tick_sel && !pipe_r[1] && cnt_r != CNT_FULL)
			|=> cnt_r == $past(cnt_r) + 1'b1)
			else $error("low sample not counted");
		fall_edge_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
			(!low_mode && pipe_r[2] && !pipe_r[1] && $stable(evt.mode[i])) |=> det_r)
			else $error("falling edge missed");
	end

endmodule : podu_req_det

/* File: podu_timer_model.sv */
// timer side model: complementary pwm pairs with a commanded short
`timescale 1ns/1ns
module podu_timer_model
	import podu_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic short_on,
	input wire logic [2:0] short_sel,
	input wire logic [PIN_N-1:0] oe_off,
	output logic [PIN_N-1:0] timer_level,
	output logic [PIN_N-1:0] timer_oe
);
	logic phase_r;

	// pwm phase flips every cycle
	always_ff @(posedge ref_clk) begin
		phase_r <= reset_n ? ~phase_r : 1'b0;
	end

	// b members are the inverse of a members, unless a short is commanded
	always_comb begin
		timer_oe = ~oe_off; // timer's own enables, steered by the bench
		timer_level = {PIN_N{phase_r}} ^ 16'hCB20;
		if (short_on) begin
			timer_level[PAIR_A_IDX[short_sel]] = 1'b1;
			timer_level[PAIR_B_IDX[short_sel]] = 1'b1;
		end
	end
endmodule : podu_timer_model

/* File: podu_top.sv */
// port output disable unit: register file, hold-off logic and pin override
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
module podu_top
	import podu_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	input wire logic disable_req_in_0_n,
	input wire logic disable_req_in_4_n,
	input wire logic disable_req_in_8_n,
	input wire logic disable_req_in_10_n,
	input wire logic disable_req_in_11_n,
	input wire logic osc_stopped,
	input wire logic [PIN_N-1:0] timer_level,
	input wire logic [PIN_N-1:0] timer_oe,
	output logic [PIN_N-1:0] pin_level,
	output logic [PIN_N-1:0] pin_oe,
	output logic irq
);
	podu_evt_if evt ();

	// control and status state
	podu_mode_e mode_r [REQ_N];
	podu_mode_e mode_nxt [REQ_N];
	logic [REQ_N-1:0] req_hiz_en_r;
	logic [REQ_N-1:0] req_hiz_en_nxt;
	logic [REQ_N-1:0] pie_r;
	logic [REQ_N-1:0] pie_nxt;
	logic [2:0] sw_hiz_r;
	logic [2:0] sw_hiz_nxt;
	logic [3:0] oec1_r;
	logic [3:0] oec1_nxt;
	logic [PAIR_N-1:0] pair_en_r;
	logic [PAIR_N-1:0] pair_en_nxt;
	logic [PIN_N-1:0] act_lvl_r;
	logic [PIN_N-1:0] act_lvl_nxt;
	logic osc_hiz_en_r;
	logic osc_hiz_en_nxt;
	logic [ST_W-1:0] status_r;
	logic [ST_W-1:0] status_nxt;
	logic [ST_W-1:0] irq_en_r;
	logic [ST_W-1:0] irq_en_nxt;

	// synchroniser, prescaler and registered outputs
	logic [1:0] osc_sync_r;
	logic [1:0] osc_sync_nxt;
	logic [PRESC_W-1:0] presc_r;
	logic [PRESC_W-1:0] presc_nxt;
	logic [2:0] tick_r;
	logic [2:0] tick_nxt;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rdata_nxt;
	logic [PIN_N-1:0] pin_level_r;
	logic [PIN_N-1:0] pin_oe_r;
	logic [PIN_N-1:0] pin_oe_nxt;
	logic irq_r;
	logic irq_nxt;

	// combinational helpers
	logic [ST_W-1:0] st_set;
	logic [ST_W-1:0] st_clr;
	logic [ST_W-1:0] irq_gate;
	logic [PAIR_N-1:0] pair_en_wr;
	logic global_hiz;
	logic [PIN_N-1:0] hiz;

	if (DIV_128 > (1 << PRESC_W) || PIN_N != 16 || ST_W != ST_OSC_BIT + 1) begin : g_chk
		$error("podu_top: constants do not fit the logic");
	end

	// register decode, used for every access
	function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] target);
		hit = (addr == target);
	endfunction : hit

	function automatic logic [7:0] icsr_addr(input int idx);
		icsr_addr = ADDR_ICSR_BASE + 8'(idx) * ADDR_ICSR_STEP;
	endfunction : icsr_addr

	// prescaler strobe for a power-of-two divider
	function automatic logic div_tick(input logic [PRESC_W-1:0] cnt, input int div);
		div_tick = ((cnt & PRESC_W'(div - 1)) == PRESC_W'(div - 1));
	endfunction : div_tick

	// detectors
	podu_req_det #(
		.N(REQ_N),
		.SAMPLES(LOW_SAMPLES)
	) u_req_det (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.req_in_n({disable_req_in_11_n, disable_req_in_10_n, disable_req_in_8_n,
			disable_req_in_4_n, disable_req_in_0_n}),
		.evt(evt.det)
	);

	podu_pair_cmp u_pair_cmp (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.evt(evt.cmp)
	);

	// detector feeds
	always_comb begin
		evt.tick = tick_r;
		evt.level = timer_level;
		evt.active_level = act_lvl_r;
		for (int i = 0; i < REQ_N; i++) begin
			evt.mode[i] = mode_r[i];
		end
	end

	// sampling clock strobes and oscillator stop synchroniser
	always_comb begin
		presc_nxt = presc_r + 1'b1;
		tick_nxt[0] = div_tick(presc_r, DIV_8);
		tick_nxt[1] = div_tick(presc_r, DIV_16);
		tick_nxt[2] = div_tick(presc_r, DIV_128);
		osc_sync_nxt = {osc_sync_r[0], osc_stopped};
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			presc_r <= '0;
			tick_r <= '0;
			osc_sync_r <= '0;
		end else begin
			presc_r <= presc_nxt;
			tick_r <= tick_nxt;
			osc_sync_r <= osc_sync_nxt;
		end
	end

	// register writes and sticky status
	always_comb begin
		mode_nxt = mode_r;
		req_hiz_en_nxt = req_hiz_en_r;
		pie_nxt = pie_r;
		sw_hiz_nxt = sw_hiz_r;
		oec1_nxt = oec1_r;
		pair_en_nxt = pair_en_r;
		act_lvl_nxt = act_lvl_r;
		osc_hiz_en_nxt = osc_hiz_en_r;
		irq_en_nxt = irq_en_r;
		st_clr = '0;
		for (int j = 0; j < PAIR_N; j++) begin
			pair_en_wr[j] = reg_wdata[PAIR_EN_BIT[j]];
		end
		if (reg_wr) begin
			for (int i = 0; i < REQ_N; i++) begin
				if (hit(reg_addr, icsr_addr(i))) begin
					mode_nxt[i] = podu_mode_e'(reg_wdata[ICSR_MODE_LSB +: 2]);
					req_hiz_en_nxt[i] = reg_wdata[ICSR_HIZ_BIT];
					pie_nxt[i] = reg_wdata[ICSR_PIE_BIT];
				end
			end
			if (hit(reg_addr, ADDR_SW_HIZ)) begin
				sw_hiz_nxt = reg_wdata[2:0];
			end
			if (hit(reg_addr, ADDR_OEC1)) begin
				oec1_nxt = reg_wdata[3:0];
			end
			if (hit(reg_addr, ADDR_OEC2)) begin
				pair_en_nxt = pair_en_wr;
			end
			if (hit(reg_addr, ADDR_ACT_LVL)) begin
				act_lvl_nxt = reg_wdata;
			end
			if (hit(reg_addr, ADDR_OSC_CTRL)) begin
				osc_hiz_en_nxt = reg_wdata[0];
			end
			if (hit(reg_addr, ADDR_IRQ_CLR)) begin
				st_clr = reg_wdata[ST_W-1:0];
			end
			if (hit(reg_addr, ADDR_IRQ_EN)) begin
				irq_en_nxt = reg_wdata[ST_W-1:0];
			end
		end
		st_set = '0;
		st_set[ST_REQ_LSB +: REQ_N] = evt.req_det;
		st_set[ST_PAIR_LSB +: PAIR_N] = evt.short_det;
		st_set[ST_OSC_BIT] = osc_sync_r[1];
		status_nxt = (status_r & ~st_clr) | st_set;
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			for (int i = 0; i < REQ_N; i++) begin
				mode_r[i] <= PODU_MODE_FALL;
			end
			req_hiz_en_r <= '0;
			pie_r <= '0;
			sw_hiz_r <= '0;
			oec1_r <= '0;
			pair_en_r <= '0;
			act_lvl_r <= ACT_LVL_RST;
			osc_hiz_en_r <= 1'b0;
			status_r <= '0;
			irq_en_r <= '0;
		end else begin
			mode_r <= mode_nxt;
			req_hiz_en_r <= req_hiz_en_nxt;
			pie_r <= pie_nxt;
			sw_hiz_r <= sw_hiz_nxt;
			oec1_r <= oec1_nxt;
			pair_en_r <= pair_en_nxt;
			act_lvl_r <= act_lvl_nxt;
			osc_hiz_en_r <= osc_hiz_en_nxt;
			status_r <= status_nxt;
			irq_en_r <= irq_en_nxt;
		end
	end

	// pin override, read data and interrupt
	always_comb begin
		global_hiz = |(status_r[ST_REQ_LSB +: REQ_N] & req_hiz_en_r)
			| |(status_r[ST_PAIR_LSB +: PAIR_N] & pair_en_r)
			| (status_r[ST_OSC_BIT] & osc_hiz_en_r);
		hiz = '0;
		hiz[3:0] = ({4{global_hiz}} & oec1_r) | {4{sw_hiz_r[SW_CH0_BIT]}};
		hiz = hiz | ({PIN_N{global_hiz | sw_hiz_r[SW_CH34_BIT]}} & CH34_MASK);
		hiz = hiz | ({PIN_N{global_hiz | sw_hiz_r[SW_CH67_BIT]}} & CH67_MASK);
		pin_oe_nxt = timer_oe & ~hiz;
		irq_gate = irq_en_r;
		irq_gate[ST_REQ_LSB +: REQ_N] = irq_en_r[ST_REQ_LSB +: REQ_N] & pie_r;
		irq_nxt = |(status_r & irq_gate);
		rdata_nxt = '0;
		if (reg_rd) begin
			for (int i = 0; i < REQ_N; i++) begin
				if (hit(reg_addr, icsr_addr(i))) begin
					rdata_nxt[ICSR_MODE_LSB +: 2] = mode_r[i];
					rdata_nxt[ICSR_HIZ_BIT] = req_hiz_en_r[i];
					rdata_nxt[ICSR_PIE_BIT] = pie_r[i];
					rdata_nxt[ICSR_FLAG_BIT] = status_r[ST_REQ_LSB + i];
				end
			end
			if (hit(reg_addr, ADDR_SW_HIZ)) begin
				rdata_nxt[2:0] = sw_hiz_r;
			end
			if (hit(reg_addr, ADDR_OEC1)) begin
				rdata_nxt[3:0] = oec1_r;
			end
			if (hit(reg_addr, ADDR_OEC2)) begin
				for (int j = 0; j < PAIR_N; j++) begin
					rdata_nxt[PAIR_EN_BIT[j]] = pair_en_r[j];
				end
			end
			if (hit(reg_addr, ADDR_ACT_LVL)) begin
				rdata_nxt = act_lvl_r;
			end
			if (hit(reg_addr, ADDR_OSC_CTRL)) begin
				rdata_nxt[0] = osc_hiz_en_r;
			end
			if (hit(reg_addr, ADDR_IRQ_STAT)) begin
				rdata_nxt[ST_W-1:0] = status_r;
			end
			if (hit(reg_addr, ADDR_IRQ_EN)) begin
				rdata_nxt[ST_W-1:0] = irq_en_r;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			pin_level_r <= '0;
			pin_oe_r <= '0;
			irq_r <= 1'b0;
			rdata_r <= '0;
		end else begin
			pin_level_r <= timer_level;
			pin_oe_r <= pin_oe_nxt;
			irq_r <= irq_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign pin_level = pin_level_r;
	assign pin_oe = pin_oe_r;
	assign irq = irq_r;
	assign reg_rdata = rdata_r;

	// checks on the override and status behaviour
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	hiz_pins_a: assert property ((pin_oe_r & $past(hiz)) == '0)
		else $error("pin driven while disabled");
	req_hiz_a: assert property (status_r[ST_REQ_LSB] && req_hiz_en_r[0]
		|=> pin_oe_r[15:4] == '0)
		else $error("request did not disable pins");
	pair_flag_a: assert property ((timer_level[4] == act_lvl_r[4])
		&& (timer_level[5] == act_lvl_r[5]) |-> ##2 status_r[ST_PAIR_LSB])
		else $error("pair short not flagged");
	osc_hiz_a: assert property (status_r[ST_OSC_BIT] && osc_hiz_en_r
		|=> pin_oe_r[15:4] == '0)
		else $error("oscillator stop did not disable pins");
	sw_ch67_a: assert property (sw_hiz_r[SW_CH67_BIT] |=> pin_oe_r[15:10] == '0)
		else $error("software request ignored");
	sw_ch0_a: assert property (sw_hiz_r[SW_CH0_BIT] |=> pin_oe_r[3:0] == '0)
		else $error("channel 0 software request ignored");
	sw_ch34_a: assert property (sw_hiz_r[SW_CH34_BIT] |=> pin_oe_r[9:4] == '0)
		else $error("channel 3 and 4 software request ignored");
	pair_gate_a: assert property ((status_r[ST_PAIR_LSB +: PAIR_N] & pair_en_r) == '0
		&& status_r[ST_REQ_LSB +: REQ_N] == '0 && !status_r[ST_OSC_BIT] && sw_hiz_r == '0
		|=> pin_oe_r == $past(timer_oe))
		else $error("pins disabled with no enabled cause");
	ch0_gate_a: assert property (!oec1_r[0] && !sw_hiz_r[SW_CH0_BIT]
		|=> pin_oe_r[0] == $past(timer_oe[0]))
		else $error("channel 0 pin disabled without enable");
	irq_raise_a: assert property (status_r[ST_REQ_LSB] && irq_en_r[ST_REQ_LSB] && pie_r[0]
		|=> irq_r)
		else $error("interrupt not raised");
	flag_hold_a: assert property (status_r[ST_PAIR_LSB]
		&& !(reg_wr && reg_addr == ADDR_IRQ_CLR && reg_wdata[ST_PAIR_LSB])
		|=> status_r[ST_PAIR_LSB])
		else $error("flag lost without clear");
	rdata_idle_a: assert property (!reg_rd |=> reg_rdata == '0)
		else $error("read data outside read slot");

endmodule : podu_top

/* File: testbench.sv */
// self-checking bench of the port output disable unit
`timescale 1ns/1ns
module testbench
	import podu_pkg::*;
;
	logic ref_clk, reset_n, reg_wr, reg_rd, osc_stopped, short_on, irq;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata, reg_rdata, rd_val;
	logic [4:0] req_n;
	logic [2:0] short_sel;
	logic [PIN_N-1:0] timer_level, timer_oe, pin_level, pin_oe, oe_off;
	int err_count, samples_checked, cycles;
	localparam int DIVS [3] = '{DIV_8, DIV_16, DIV_128};
	localparam logic [15:0] SW_MASK [3] = '{CH34_MASK, CH67_MASK, CH0_MASK};

	podu_top dut (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.disable_req_in_0_n(req_n[0]), .disable_req_in_4_n(req_n[1]),
		.disable_req_in_8_n(req_n[2]), .disable_req_in_10_n(req_n[3]),
		.disable_req_in_11_n(req_n[4]), .osc_stopped(osc_stopped),
		.timer_level(timer_level), .timer_oe(timer_oe), .pin_level(pin_level),
		.pin_oe(pin_oe), .irq(irq));

	podu_timer_model model (.ref_clk(ref_clk), .reset_n(reset_n), .short_on(short_on),
		.short_sel(short_sel), .oe_off(oe_off), .timer_level(timer_level),
		.timer_oe(timer_oe));

	// clock
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic wrap_up();
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : wrap_up

	// hang guard
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 30000) begin
			err_count++;
			$display("mismatch at %0t: run timed out", $time);
			wrap_up();
		end
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		rd_val = reg_rdata;
	endtask : rd

	function automatic logic [7:0] icsr(input int i);
		return ADDR_ICSR_BASE + 8'(i) * ADDR_ICSR_STEP;
	endfunction : icsr

	// bounded wait for the pin enables, then compare
	task automatic wait_oe(input logic [15:0] exp);
		int n;
		n = 0;
		while (pin_oe !== exp && n < 60) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		check(pin_oe, exp, "pin_oe");
	endtask : wait_oe

	task automatic poll_st(input int b);
		int n;
		n = 0;
		rd(ADDR_IRQ_STAT);
		while (rd_val[b] !== 1'b1 && n < 40) begin
			rd(ADDR_IRQ_STAT);
			n++;
		end
		check(16'(rd_val[b]), 16'h0001, "status bit");
	endtask : poll_st

	task automatic irq_is(input logic exp);
		repeat (2) @(posedge ref_clk);
		#1;
		check(16'(irq), 16'(exp), "irq");
	endtask : irq_is

	// one-cycle overlap of both members of pair p
	task automatic short_pair(input int p);
		@(posedge ref_clk);
		short_sel <= 3'(p);
		short_on <= 1'b1;
		@(posedge ref_clk);
		short_on <= 1'b0;
		poll_st(ST_PAIR_LSB + p);
	endtask : short_pair

	initial begin
		reset_n = 1'b0;
		{reg_wr, reg_rd, osc_stopped, short_on} = 4'h0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		req_n = 5'h1F;
		short_sel = 3'h0;
		oe_off = 16'h0000;
		repeat (20) @(posedge ref_clk);
		#1;
		check(pin_oe, 16'h0000, "oe in reset");
		@(posedge ref_clk) reset_n <= 1'b1;
		wait_oe(16'hFFFF);
		// pin levels follow the timer one cycle later
		@(posedge ref_clk);
		#1;
		rd_val = timer_level;
		@(posedge ref_clk);
		#1;
		check(pin_level, rd_val, "pin level copy");
		rd(ADDR_ACT_LVL);
		check(rd_val, ACT_LVL_RST, "active level reset");
		foreach (DIVS[k]) begin
			rd(icsr(k));
			check(rd_val, 16'h0000, "input control reset");
		end
		wr(ADDR_IRQ_STAT, 16'hFFFF);
		rd(ADDR_IRQ_STAT);
		check(rd_val, 16'h0000, "status write ignored");
		rd(8'h20);
		check(rd_val, 16'h0000, "unmapped read");
		// software request bits, one group each
		for (int i = 0; i < 3; i++) begin
			wr(ADDR_SW_HIZ, 16'h0001 << i);
			wait_oe(~SW_MASK[i]);
		end
		wr(ADDR_SW_HIZ, 16'h0000);
		wait_oe(16'hFFFF);
		// timer's own enables pass through and are masked by a request
		@(posedge ref_clk) oe_off <= 16'h0F0F;
		wait_oe(16'hF0F0);
		wr(ADDR_SW_HIZ, 16'h0001);
		wait_oe(16'hF000);
		wr(ADDR_SW_HIZ, 16'h0000);
		@(posedge ref_clk) oe_off <= 16'h0000;
		wait_oe(16'hFFFF);
		// falling edge on each request input, ch0 pins dropped from OEC1 one by one
		for (int i = 0; i < REQ_N; i++) begin
			wr(ADDR_OEC1, 16'h000F >> i);
			wr(icsr(i), 16'h0100);
			@(posedge ref_clk) req_n[i] <= 1'b0;
			poll_st(ST_REQ_LSB + i);
			wait_oe(16'h000F & ~(16'h000F >> i));
			rd(icsr(i));
			check(rd_val, 16'h1100, "flag in control");
			@(posedge ref_clk) req_n[i] <= 1'b1;
			repeat (20) @(posedge ref_clk);
			#1;
			check(pin_oe, 16'h000F & ~(16'h000F >> i), "held");
			wr(ADDR_IRQ_CLR, 16'h0001 << i);
			wait_oe(16'hFFFF);
			wr(icsr(i), 16'h1000);
			rd(icsr(i));
			check(rd_val, 16'h0000, "flag read only");
		end
		// low-level sampling on input 4 at each divider
		wr(ADDR_OEC1, 16'h000F);
		for (int m = 1; m < 4; m++) begin
			wr(icsr(1), 16'h0100 | 16'(m));
			@(posedge ref_clk) req_n[1] <= 1'b0;
			repeat (14 * DIVS[m-1]) @(posedge ref_clk);
			req_n[1] <= 1'b1;
			rd(ADDR_IRQ_STAT);
			check(rd_val, 16'h0000, "short low ignored");
			repeat (2 * DIVS[m-1]) @(posedge ref_clk);
			req_n[1] <= 1'b0;
			repeat (17 * DIVS[m-1] + 8) @(posedge ref_clk);
			rd(ADDR_IRQ_STAT);
			check(rd_val, 16'h0002, "long low seen");
			wait_oe(16'h0000);
			@(posedge ref_clk) req_n[1] <= 1'b1;
			// detector holds until a high sample lands on a strobe
			repeat (DIVS[m-1] + 4) @(posedge ref_clk);
			wr(ADDR_IRQ_CLR, 16'h0002);
			wait_oe(16'hFFFF);
		end
		wr(icsr(1), 16'h0000);
		// each pair: disabled leaves pins alone, enabled disables them
		for (int p = 0; p < PAIR_N; p++) begin
			wr(ADDR_OEC2, 16'h0707 ^ (16'h0001 << PAIR_EN_BIT[p]));
			short_pair(p);
			check(pin_oe, 16'hFFFF, "pair disabled");
			wr(ADDR_IRQ_CLR, 16'h0001 << (ST_PAIR_LSB + p));
			wr(ADDR_OEC2, 16'h0001 << PAIR_EN_BIT[p]);
			short_pair(p);
			wait_oe(16'h0000);
			wr(ADDR_IRQ_CLR, 16'h0001 << (ST_PAIR_LSB + p));
			wait_oe(16'hFFFF);
		end
		wr(ADDR_OEC2, 16'h0000);
		// oscillator stop
		wr(ADDR_OSC_CTRL, 16'h0001);
		@(posedge ref_clk) osc_stopped <= 1'b1;
		poll_st(ST_OSC_BIT);
		wait_oe(16'h0000);
		@(posedge ref_clk) osc_stopped <= 1'b0;
		repeat (4) @(posedge ref_clk);
		wr(ADDR_IRQ_CLR, 16'h0800);
		wait_oe(16'hFFFF);
		// interrupt from pair comparison: raise, mask, unmask, clear
		wr(ADDR_IRQ_EN, 16'h0001 << ST_PAIR_LSB);
		short_pair(0);
		irq_is(1'b1);
		wr(ADDR_IRQ_EN, 16'h0000);
		irq_is(1'b0);
		wr(ADDR_IRQ_EN, 16'h0001 << ST_PAIR_LSB);
		irq_is(1'b1);
		wr(ADDR_IRQ_CLR, 16'h0001 << ST_PAIR_LSB);
		irq_is(1'b0);
		// interrupt from request input needs the port enable too
		wr(icsr(0), 16'h0200);
		wr(ADDR_IRQ_EN, 16'h0001);
		@(posedge ref_clk) req_n[0] <= 1'b0;
		poll_st(0);
		irq_is(1'b1);
		check(pin_oe, 16'hFFFF, "no hiz without enable");
		wr(icsr(0), 16'h0000);
		irq_is(1'b0);
		@(posedge ref_clk) req_n[0] <= 1'b1;
		repeat (4) @(posedge ref_clk);
		wr(ADDR_IRQ_CLR, 16'h0001);
		rd(ADDR_IRQ_STAT);
		check(rd_val, 16'h0000, "all cleared");
		wrap_up();
	end
endmodule : testbench
